/* hdl/smbra_pkg.sv */
// smbra_pkg: constants, state type and crc helper for the smbus ram/nvm slave.
// assumes a 100 MHz system clock; all timings below derive from that rate.
package smbra_pkg;
  // clock and nonvolatile timings
  localparam int CLK_MHZ       = 100;
  localparam int PROG_TIME_US  = 250;
  localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_TIME_MS = 20;
  localparam int ERASE_CYCLES  = ERASE_TIME_MS * 1000 * CLK_MHZ;
  // addressing and command codes
  localparam logic [4:0] SLAVE_ADDR_HI  = 5'h09;
  localparam logic [7:0] RAM_TOP        = 8'hDF;
  localparam logic [7:0] NV_HI_MIN      = 8'hF8;
  localparam logic [7:0] NV_HI_MAX      = 8'hFB;
  localparam logic [7:0] CMD_BLK_WR     = 8'hFC;
  localparam logic [7:0] CMD_BLK_RD     = 8'hFD;
  localparam logic [7:0] CMD_ERASE      = 8'hFE;
  localparam logic [7:0] UPD_CFG_ADDR   = 8'h90;
  localparam int         UPD_ERASE_BIT  = 2;
  localparam logic [7:0] BLK_RD_LEN     = 8'h20;
  localparam logic [5:0] BLK_RD_PEC_IDX = 6'h21;
  localparam logic [7:0] CRC_POLY       = 8'h07;
  localparam logic [7:0] RAM_RST_VAL    = 8'h00;
  localparam logic [7:0] ERASED_VAL     = 8'hFF;
  // memory sizes and write queue shape
  localparam int RAM_BYTES  = 224;
  localparam int NV_BYTES   = 1024;
  localparam int PAGE_BYTES = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W     = 25;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RECV = 5'b00010,
    ST_ACKW = 5'b00100,
    ST_SEND = 5'b01000,
    ST_ACKR = 5'b10000
  } smbra_state_type;

  // one byte of crc-8, msb first, no reflection
  function automatic logic [7:0] smbra_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ({x[6:0], 1'b0} ^ CRC_POLY) : {x[6:0], 1'b0};
    end
    return x;
  endfunction
endpackage

/* hdl/smbra_fifo_if.sv */
// smbra_fifo_if: valid/ready carrier between the slave and its write queue.
// assumes both ends sit on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface smbra_fifo_if #(parameter int W = 8);
  logic [W-1:0] in_data;
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] out_data;
  logic         out_valid;
  logic         out_ready;
  modport fifo (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
  modport user (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
endinterface
`default_nettype wire

/* hdl/smbra_fifo.sv */
// smbra_fifo: small first-in first-out queue with valid/ready on both sides.
// assumes DEPTH is a power of two and at least 2.
`timescale 1ns/100ps
`default_nettype none
module smbra_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic      sys_clk_i,
  input  wire logic      arst_n_i,
  // queue ports
  smbra_fifo_if.fifo     f
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         full;
  logic         empty;

  // extra pointer bit tells full from empty without a counter
  assign full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty       = (wr_q == rd_q);
  assign f.in_ready  = !full;
  assign f.out_valid = !empty;
  assign f.out_data  = mem_q[rd_q[AW-1:0]];

  // storage needs no reset, only the pointers do
  always_ff @(posedge sys_clk_i) begin
    if (f.in_valid && !full) begin
      mem_q[wr_q[AW-1:0]] <= f.in_data;
    end
  end

  // pointers
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (f.in_valid && !full) begin
        wr_q <= wr_q + 1'b1;
      end
      if (f.out_ready && !empty) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  a_fifo_level: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (AW + 1)'(wr_q - rd_q) <= (AW + 1)'(DEPTH))
    else $error("queue holds more words than its depth");
endmodule
`default_nettype wire

/* hdl/smbra_slave.sv */
// smbra_slave: smbus slave giving access to 224 bytes of ram and 1 KiB of paged nvm.
// assumes scl and sda arrive asynchronously and are open drain; the bus scl runs
// far below the system clock so edges are found by sampling.
// How it works
// - write byte to ram stores data byte
// - nvm command plus one byte sets pointer
// - erase page uses pointer bits five and up
// - nvm command plus two bytes programs location
// - 0xFC takes count then stores bytes
// - scl held low while queue cannot accept
// - receive byte returns byte at pointer
// - block read sends count 32, 32 bytes
// - optional pec byte ends transfers; only block read sends one, and no received pec byte is checked
// - pec is crc-8 polynomial 0x07
// - address, command and data bytes acknowledged
// - send byte ram command loads pointer
// - 0xFE erases page when enable bit set
// - no acknowledge while page erase runs
// - address is 01001 plus two pins
`timescale 1ns/100ps
`default_nettype none
module smbra_slave import smbra_pkg::*; #(
  parameter int PROG_CYC  = PROG_CYCLES,
  parameter int ERASE_CYC = ERASE_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  // smbus clock, open drain
  input  wire logic scl_i,
  output logic      scl_o,
  output logic      scl_oe_o,
  // smbus data, open drain
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  // address straps
  input  wire logic address_select_pin_high_i,
  input  wire logic address_select_pin_low_i,
  // status
  output logic      nvm_busy_o
);
  smbra_state_type state_q;
  logic [2:0]  scl_s;
  logic [2:0]  sda_s;
  logic [1:0]  ahi_s;
  logic [1:0]  alo_s;
  logic [3:0]  bit_q;
  logic [7:0]  shift_q;
  logic [2:0]  byte_idx_q;
  logic        rw_q;
  logic [7:0]  cmd_q;
  logic [7:0]  cnt_q;
  logic [15:0] ptr_q;
  logic        nv_sel_q;
  logic        blk_rd_q;
  logic [7:0]  tx_q;
  logic [5:0]  tx_idx_q;
  logic [7:0]  crc_q;
  logic        in_xfer_q;
  logic        sda_oe_q;
  logic        stretch_q;
  logic [21:0] busy_cnt_q;
  logic        erasing_q;
  logic [7:0]  ram_q [RAM_BYTES];
  logic [7:0]  nv_q  [NV_BYTES];
  logic        scl_rise, scl_fall, start_det, stop_det;
  logic        addr_match, push_need, wr_stall, wr_go, rd_stall, rd_go, load_go;
  logic        nvm_busy, erase_go, pop, head_nv;
  logic [15:0] head_addr;
  logic [7:0]  head_data, mem_rd, tx_byte;
  smbra_fifo_if #(.W(FIFO_W)) wq ();

  function automatic logic is_nv_cmd(input logic [7:0] b);
    return (b >= NV_HI_MIN) && (b <= NV_HI_MAX);
  endfunction
  function automatic logic in_nv(input logic [15:0] a);
    return a[15:10] == NV_HI_MIN[7:2];
  endfunction

  // two flops per pin, then a third stage only for edge finding
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      ahi_s <= 2'h0;
      alo_s <= 2'h0;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
      ahi_s <= {ahi_s[0], address_select_pin_high_i};
      alo_s <= {alo_s[0], address_select_pin_low_i};
    end
  end

  // bus events seen from the second and third stages only
  assign scl_rise  = scl_s[1] && !scl_s[2];
  assign scl_fall  = !scl_s[1] && scl_s[2];
  assign start_det = scl_s[1] && scl_s[2] && sda_s[2] && !sda_s[1];
  assign stop_det  = scl_s[1] && scl_s[2] && !sda_s[2] && sda_s[1];
  // no answer at all while a page erase is running
  assign addr_match = (shift_q[7:1] == {SLAVE_ADDR_HI, ahi_s[1], alo_s[1]})
                      && !erasing_q;

  // which received bytes go to memory through the queue
  assign push_need = ((byte_idx_q == 3'd2) && (cmd_q <= RAM_TOP))
                  || ((byte_idx_q == 3'd3) && is_nv_cmd(cmd_q))
                  || ((byte_idx_q >= 3'd3) && (cmd_q == CMD_BLK_WR)
                      && (cnt_q != 8'h00));
  assign wr_stall = (state_q == ST_RECV) && (bit_q == 4'd8) && scl_fall && !stretch_q
                    && push_need && !wq.in_ready;
  assign wr_go    = (state_q == ST_RECV) && (bit_q == 4'd8) && (stretch_q || scl_fall)
                    && (!push_need || wq.in_ready);
  // reads wait until queued writes have landed so they see fresh data
  assign rd_stall = (state_q == ST_ACKW) && rw_q && scl_fall && !stretch_q && wq.out_valid;
  assign rd_go    = (state_q == ST_ACKW) && rw_q && (stretch_q || scl_fall) && !wq.out_valid;
  assign load_go  = rd_go || ((state_q == ST_ACKR) && scl_fall && !sda_s[1]);

  // byte to send next: count, data, then the check byte
  assign mem_rd  = nv_sel_q ? (in_nv(ptr_q) ? nv_q[ptr_q[9:0]] : ERASED_VAL)
                            : ((ptr_q <= {8'h00, RAM_TOP}) ? ram_q[ptr_q[7:0]] : RAM_RST_VAL);
  always_comb begin
    tx_byte = mem_rd;
    if (blk_rd_q && (tx_idx_q == 6'h00)) begin
      tx_byte = BLK_RD_LEN;
    end else if (blk_rd_q && (tx_idx_q == BLK_RD_PEC_IDX)) begin
      tx_byte = crc_q;
    end else if (blk_rd_q && (tx_idx_q > BLK_RD_PEC_IDX)) begin
      tx_byte = ERASED_VAL;
    end
  end

  assign wq.in_valid = wr_go && push_need;
  assign wq.in_data  = {nv_sel_q, ptr_q, shift_q};

  // protocol engine
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q    <= ST_IDLE;
      bit_q      <= 4'h0;
      shift_q    <= 8'h00;
      byte_idx_q <= 3'h0;
      rw_q       <= 1'b0;
      cmd_q      <= 8'h00;
      cnt_q      <= 8'h00;
      ptr_q      <= 16'h0000;
      nv_sel_q   <= 1'b0;
      blk_rd_q   <= 1'b0;
      tx_q       <= 8'h00;
      tx_idx_q   <= 6'h00;
      crc_q      <= 8'h00;
      in_xfer_q  <= 1'b0;
      sda_oe_q   <= 1'b0;
      stretch_q  <= 1'b0;
    end else if (start_det) begin
      state_q    <= ST_RECV;
      bit_q      <= 4'h0;
      byte_idx_q <= 3'h0;
      sda_oe_q   <= 1'b0;
      stretch_q  <= 1'b0;
      in_xfer_q  <= 1'b1;
      // a repeated start keeps the running check value
      if (!in_xfer_q) begin
        crc_q <= 8'h00;
      end
    end else if (stop_det) begin
      state_q   <= ST_IDLE;
      sda_oe_q  <= 1'b0;
      stretch_q <= 1'b0;
      in_xfer_q <= 1'b0;
      blk_rd_q  <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        ST_RECV: begin
          if (scl_rise && (bit_q != 4'd8)) begin
            shift_q <= {shift_q[6:0], sda_s[1]};
            bit_q   <= bit_q + 4'd1;
          end
          if (wr_stall) begin
            stretch_q <= 1'b1;
          end
          if (wr_go) begin
            stretch_q <= 1'b0;
            bit_q     <= 4'h0;
            crc_q     <= smbra_crc8(crc_q, shift_q);
            if (byte_idx_q != 3'd4) begin
              byte_idx_q <= byte_idx_q + 3'd1;
            end
            if (byte_idx_q == 3'd0) begin
              rw_q     <= shift_q[0];
              tx_idx_q <= 6'h00;
              sda_oe_q <= addr_match;
              state_q  <= addr_match ? ST_ACKW : ST_IDLE;
            end else begin
              sda_oe_q <= 1'b1;
              state_q  <= ST_ACKW;
              if (push_need) begin
                ptr_q <= ptr_q + 16'h0001;
                if (cmd_q == CMD_BLK_WR) begin
                  cnt_q <= cnt_q - 8'h01;
                end
              end else if (byte_idx_q == 3'd1) begin
                cmd_q <= shift_q;
                if (shift_q <= RAM_TOP) begin
                  ptr_q    <= {8'h00, shift_q};
                  nv_sel_q <= 1'b0;
                end
                if (shift_q == CMD_BLK_RD) begin
                  blk_rd_q <= 1'b1;
                end
              end else if (byte_idx_q == 3'd2) begin
                if (is_nv_cmd(cmd_q)) begin
                  ptr_q    <= {cmd_q, shift_q};
                  nv_sel_q <= 1'b1;
                end
                if (cmd_q == CMD_BLK_WR) begin
                  cnt_q <= shift_q;
                end
              end
            end
          end
        end
        ST_ACKW: begin
          if (rd_stall) begin
            stretch_q <= 1'b1;
          end
          if (rd_go) begin
            stretch_q <= 1'b0;
          end else if (!rw_q && scl_fall) begin
            sda_oe_q <= 1'b0;
            state_q  <= ST_RECV;
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (bit_q == 4'd7) begin
              sda_oe_q <= 1'b0;
              state_q  <= ST_ACKR;
            end else begin
              tx_q     <= {tx_q[6:0], 1'b0};
              sda_oe_q <= !tx_q[6];
              bit_q    <= bit_q + 4'd1;
            end
          end
        end
        ST_ACKR: begin
          // a nack from the master ends the read
          if (scl_rise && sda_s[1]) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // load the next byte to send, after the ack slot
      if (load_go) begin
        state_q  <= ST_SEND;
        tx_q     <= tx_byte;
        sda_oe_q <= !tx_byte[7];
        bit_q    <= 4'h0;
        if (tx_idx_q != 6'h3F) begin
          tx_idx_q <= tx_idx_q + 6'h01;
        end
        if (!blk_rd_q || (tx_idx_q < BLK_RD_PEC_IDX)) begin
          crc_q <= smbra_crc8(crc_q, tx_byte);
        end
        if (!blk_rd_q || ((tx_idx_q != 6'h00) && (tx_idx_q < BLK_RD_PEC_IDX))) begin
          ptr_q <= ptr_q + 16'h0001;
        end
      end
    end
  end

  // write queue drains into memory; nvm writes and erases keep it waiting
  assign {head_nv, head_addr, head_data} = wq.out_data;
  assign nvm_busy     = (busy_cnt_q != 22'h00_0000);
  assign erase_go     = wr_go && (byte_idx_q == 3'd1) && (shift_q == CMD_ERASE)
                        && ram_q[UPD_CFG_ADDR][UPD_ERASE_BIT] && !nvm_busy
                        && !wq.out_valid;
  assign pop          = wq.out_valid && !nvm_busy && !erase_go;
  assign wq.out_ready = pop;

  // programming and erase timers
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_cnt_q <= 22'h00_0000;
      erasing_q  <= 1'b0;
    end else if (erase_go) begin
      busy_cnt_q <= 22'(ERASE_CYC - 1);
      erasing_q  <= 1'b1;
    end else if (pop && head_nv && in_nv(head_addr)) begin
      busy_cnt_q <= 22'(PROG_CYC - 1);
    end else if (nvm_busy) begin
      busy_cnt_q <= busy_cnt_q - 22'h00_0001;
    end else begin
      erasing_q <= 1'b0;
    end
  end

  // ram: cleared at reset, written from the queue
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < RAM_BYTES; i++) begin
        ram_q[i] <= RAM_RST_VAL;
      end
    end else if (pop && !head_nv && (head_addr <= {8'h00, RAM_TOP})) begin
      ram_q[head_addr[7:0]] <= head_data;
    end
  end

  // nvm cells only clear bits when programmed; erase sets a page back to ones
  always_ff @(posedge sys_clk_i) begin
    if (pop && head_nv && in_nv(head_addr)) begin
      nv_q[head_addr[9:0]] <= nv_q[head_addr[9:0]] & head_data;
    end
    if (erase_go) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        nv_q[{ptr_q[9:5], 5'(i)}] <= ERASED_VAL;
      end
    end
  end

  smbra_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_wq (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .f         (wq.fifo)
  );

  assign scl_o      = 1'b0;
  assign scl_oe_o   = stretch_q;
  assign sda_o      = 1'b0;
  assign sda_oe_o   = sda_oe_q;
  assign nvm_busy_o = nvm_busy;

  a_addr_match: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_go && (byte_idx_q == 3'd0) && !start_det && !stop_det
    |=> (state_q == ST_ACKW) == $past(addr_match))
    else $error("address ack does not follow address compare");
  a_erase_nack: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    erasing_q && wr_go && (byte_idx_q == 3'd0) |=> !sda_oe_o && (state_q == ST_IDLE))
    else $error("address acknowledged during page erase");
  a_ram_store: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    pop && !head_nv && (head_addr <= {8'h00, RAM_TOP})
    |=> ram_q[$past(head_addr[7:0])] == $past(head_data))
    else $error("ram byte not stored");
  a_ptr_load: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_go && !start_det && !stop_det && (byte_idx_q == 3'd2) && is_nv_cmd(cmd_q)
    |=> (ptr_q == {$past(cmd_q), $past(shift_q)}) && nv_sel_q)
    else $error("nvm pointer not loaded from command and data");
  a_erase_page: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    erase_go |-> ram_q[UPD_CFG_ADDR][UPD_ERASE_BIT] ##1 erasing_q
    && (nv_q[{$past(ptr_q[9:5]), 5'h1F}] == ERASED_VAL))
    else $error("page erase without enable or without clearing");
  a_blk_count: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    load_go && !start_det && !stop_det && blk_rd_q && (tx_idx_q == 6'h00)
    |=> (tx_q == BLK_RD_LEN) && (state_q == ST_SEND))
    else $error("block read count byte is not 32");
  a_pec_byte: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    load_go && !start_det && !stop_det && blk_rd_q && (tx_idx_q == BLK_RD_PEC_IDX)
    |=> tx_q == $past(crc_q))
    else $error("check byte differs from running crc");
  // a pop in the stall cycle frees a slot, so only a stall without one must still see it full
  a_stretch_full: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_stall && !pop |=> scl_oe_o && !wq.in_ready)
    else $error("scl not held while queue is full");
  a_ptr_step: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wq.in_valid && wq.in_ready && !start_det && !stop_det
    |=> ptr_q == $past(ptr_q) + 16'h0001)
    else $error("pointer did not advance after stored byte");
  a_prog_gap: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    pop && head_nv && in_nv(head_addr) |=> nvm_busy && !pop)
    else $error("second nvm byte taken while programming");
endmodule
`default_nettype wire

/* verification/smbra_master_model.sv */
// smbra_master_model: behavioural smbus master on an open-drain two-wire bus.
// assumes the bench resolves both wires from every party's pull and feeds them back.
`timescale 1ns/100ps
`default_nettype none
module smbra_master_model (
  // clock
  input  wire logic clk_i,
  // resolved wire levels
  input  wire logic scl_i,
  input  wire logic sda_i,
  // master drives, 1 means released; hung_o goes high when a stretch wait times out
  output logic      scl_o,
  output logic      sda_o,
  output logic      hung_o
);
  // idle bus: both lines released to the pull-ups
  initial begin
    scl_o  = 1'b1;
    sda_o  = 1'b1;
    hung_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // release scl, then wait out any clock stretch by the slave, bounded
  task automatic rise();
    int w;
    scl_o <= 1'b1;
    tick(1);
    w = 0;
    while (scl_i !== 1'b1 && w < 4000) begin
      tick(1);
      w++;
    end
    if (w >= 4000) hung_o <= 1'b1;
  endtask

  // one 80 ns bit slot; sda moves one clock after scl falls, never while high
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_o <= b;
    tick(3);
    rise();
    tick(2);
    r = sda_i;
    tick(1);
    scl_o <= 1'b0;
  endtask

  // start, also serves as repeated start from a low scl
  task automatic start();
    tick(1);
    sda_o <= 1'b1;
    tick(3);
    rise();
    tick(3);
    sda_o <= 1'b0;
    tick(4);
    scl_o <= 1'b0;
  endtask

  task automatic stop();
    tick(1);
    sda_o <= 1'b0;
    tick(3);
    rise();
    tick(3);
    sda_o <= 1'b1;
    tick(4);
  endtask

  // msb first, ninth slot reads the slave's acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // read a byte, then ack to continue or nack to end
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule
`default_nettype wire

/* verification/smbus_ram_eeprom_access_bench.sv */
// smbus_ram_eeprom_access_bench: self-checking bench for the smbus ram/nvm slave.
// assumes pull-ups on both wires and short nvm timings set through parameters.
`timescale 1ns/100ps
`default_nettype none
module smbus_ram_eeprom_access_bench import smbra_pkg::*;;
  logic       sys_clk = 1'b0;
  logic       arst_n  = 1'b0;
  logic       pin_hi  = 1'b0;
  logic       pin_lo  = 1'b0;
  logic       m_scl, m_sda, hung, scl_oe, sda_oe, nvm_busy;
  logic       dut_scl, dut_sda;
  wire        scl_w, sda_w;
  int         err_total = 0;
  int         cmp_count = 0;
  int         stretch_cyc = 0;
  logic [7:0] run_crc;
  logic [7:0] ram_m [0:223];
  logic [7:0] nv_m  [0:1023];

  // wired-and of pull-up, master and slave pulls
  assign scl_w = m_scl & (!scl_oe | dut_scl);
  assign sda_w = m_sda & (!sda_oe | dut_sda);

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  smbra_slave #(.PROG_CYC(200), .ERASE_CYC(2000)) dut (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .scl_i(scl_w), .scl_o(dut_scl), .scl_oe_o(scl_oe),
    .sda_i(sda_w), .sda_o(dut_sda), .sda_oe_o(sda_oe), .address_select_pin_high_i(pin_hi),
    .address_select_pin_low_i(pin_lo), .nvm_busy_o(nvm_busy));

  smbra_master_model mst (.clk_i(sys_clk), .scl_i(scl_w), .sda_i(sda_w),
    .scl_o(m_scl), .sda_o(m_sda), .hung_o(hung));

  task automatic give_verdict();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // a stuck master wait ends the run; also count stretched cycles
  always @(posedge sys_clk) begin
    if (scl_oe === 1'b1) stretch_cyc++;
    if (hung === 1'b1) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, want, seen);
    end
  endtask

  // bit-serial crc-8, written apart from the design's byte form
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c;
    for (int i = 7; i >= 0; i--) x = (x[7] ^ b[i]) ? ({x[6:0], 1'b0} ^ CRC_POLY) : {x[6:0], 1'b0};
    return x;
  endfunction

  function automatic logic [7:0] exp_at(input logic [15:0] p);
    if (p[15:8] == 8'h00) return (p[7:0] <= RAM_TOP) ? ram_m[p[7:0]] : 8'h00;
    return nv_m[p[9:0]];
  endfunction

  task automatic put(input logic [7:0] b);
    logic ack;
    mst.wr_byte(b, ack);
    run_crc = crc_step(run_crc, b);
    check("ack", {7'h00, ack}, 8'h01);
  endtask

  task automatic wr_seq(input logic [7:0] q[$], input logic pec);
    run_crc = 8'h00;
    mst.start();
    put({SLAVE_ADDR_HI, pin_hi, pin_lo, 1'b0});
    foreach (q[i]) put(q[i]);
    if (pec) put(run_crc);
    mst.stop();
  endtask

  task automatic try_addr(input logic [6:0] a, input logic want);
    logic ack;
    mst.start();
    mst.wr_byte({a, 1'b0}, ack);
    mst.stop();
    check("addr_ack", {7'h00, ack}, {7'h00, want});
  endtask

  task automatic rd_one(input logic [7:0] want);
    logic [7:0] d;
    mst.start();
    put({SLAVE_ADDR_HI, pin_hi, pin_lo, 1'b1});
    mst.rd_byte(1'b0, d);
    mst.stop();
    check("byte", d, want);
  endtask

  task automatic blk_rd(input logic [15:0] p);
    logic [7:0] d;
    logic [7:0] want;
    run_crc = 8'h00;
    mst.start();
    put({SLAVE_ADDR_HI, pin_hi, pin_lo, 1'b0});
    put(CMD_BLK_RD);
    mst.start();
    put({SLAVE_ADDR_HI, pin_hi, pin_lo, 1'b1});
    mst.rd_byte(1'b1, d);
    run_crc = crc_step(run_crc, d);
    check("count", d, BLK_RD_LEN);
    for (int i = 0; i < 32; i++) begin
      mst.rd_byte(1'b1, d);
      want = exp_at(p + 16'(i));
      run_crc = crc_step(run_crc, want);
      check("data", d, want);
    end
    mst.rd_byte(1'b0, d);
    check("pec", d, run_crc);
    mst.stop();
  endtask

  task automatic wait_idle();
    int w;
    w = 0;
    check("busy", {7'h00, nvm_busy}, 8'h01);
    while (nvm_busy === 1'b1 && w < 5000) begin
      @(posedge sys_clk);
      w++;
    end
    if (w >= 5000) begin
      err_total++;
      give_verdict();
    end
  endtask

  // main sequence: straps, ram singles, ram block, nvm erase and program
  initial begin
    int         seed_v;
    int         st;
    logic [7:0] a, d, base, n;
    logic [7:0] q[$];
    seed_v = $urandom(73);
    foreach (ram_m[i]) ram_m[i] = RAM_RST_VAL;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      {pin_hi, pin_lo} <= i[1:0];
      repeat (4) @(posedge sys_clk);
      try_addr({SLAVE_ADDR_HI, i[1:0]}, 1'b1);
      try_addr({SLAVE_ADDR_HI, ~i[1:0]}, 1'b0);
    end
    {pin_hi, pin_lo} <= 2'($urandom % 4);
    repeat (4) @(posedge sys_clk);
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? 8'h00 : (k == 1) ? RAM_TOP : 8'($urandom_range(1, 8'hDE));
      if (a == UPD_CFG_ADDR) a = 8'h91;
      d = 8'($urandom);
      wr_seq('{a, d}, 1'b0);
      ram_m[a] = d;
      wr_seq('{a}, 1'b0);
      rd_one(d);
    end
    base = 8'($urandom_range(0, 120));
    n = 8'($urandom_range(2, 8));
    q = '{CMD_BLK_WR, n};
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      q.push_back(d);
      ram_m[base + k] = d;
    end
    wr_seq('{base}, 1'b0);
    wr_seq(q, 1'b1);
    // the block write moved the pointer past its data, so point back at the start
    wr_seq('{base}, 1'b0);
    blk_rd({8'h00, base});
    wr_seq('{UPD_CFG_ADDR, 8'h04}, 1'b0);
    ram_m[UPD_CFG_ADDR] = 8'h04;
    wr_seq('{NV_HI_MIN, 8'h3F}, 1'b0);
    wr_seq('{CMD_ERASE}, 1'b0);
    try_addr({SLAVE_ADDR_HI, pin_hi, pin_lo}, 1'b0);
    wait_idle();
    for (int k = 32; k < 64; k++) nv_m[k] = ERASED_VAL;
    d = 8'($urandom);
    wr_seq('{NV_HI_MIN, 8'h21, d}, 1'b0);
    nv_m[33] = d;
    wr_seq('{NV_HI_MIN, 8'h22}, 1'b0);
    q = '{CMD_BLK_WR, 8'h0A};
    for (int k = 0; k < 10; k++) begin
      d = 8'($urandom);
      q.push_back(d);
      nv_m[34 + k] = d;
    end
    st = stretch_cyc;
    wr_seq(q, 1'b0);
    check("stretch", {7'h00, stretch_cyc > st}, 8'h01);
    wr_seq('{NV_HI_MIN, 8'h20}, 1'b0);
    blk_rd(16'hF820);
    wr_seq('{UPD_CFG_ADDR, 8'h00}, 1'b0);
    wr_seq('{NV_HI_MIN, 8'h21}, 1'b0);
    wr_seq('{CMD_ERASE}, 1'b0);
    repeat (20) @(posedge sys_clk);
    check("busy_off", {7'h00, nvm_busy}, 8'h00);
    rd_one(nv_m[33]);
    give_verdict();
  end
endmodule
`default_nettype wire
